// >>> power_sleep_pkg.sv
// constants and types shared by the power/sleep gating controller
// assumes one 25 MHz clock and no software bus; requests arrive on plain ports
package power_sleep_pkg;
    localparam int INST0_COUNT = 16;
    localparam int INST1_COUNT = 32;
    localparam int INDEX_W = 5;
    localparam int CODE_W = 3;

    // request codes on the command port
    localparam logic [CODE_W-1:0] CODE_RESET_HELD_CLOCK_OFF = 3'h0;
    localparam logic [CODE_W-1:0] CODE_RESET_HELD_CLOCK_ON = 3'h1;
    localparam logic [CODE_W-1:0] CODE_DISABLE = 3'h2;
    localparam logic [CODE_W-1:0] CODE_ENABLE = 3'h3;
    localparam logic [CODE_W-1:0] CODE_AUTO_SLEEP = 3'h4;
    localparam logic [CODE_W-1:0] CODE_AUTO_WAKE = 3'h5;

    // per-instance controller tables, bit n belongs to local controller n
    localparam logic [15:0] INST0_USED = 16'hfeff;
    localparam logic [15:0] INST0_AUTO_ONLY = 16'h1c80;
    localparam logic [15:0] INST0_DEFAULT_ENABLE = 16'h9cc0;
    localparam logic [31:0] INST1_USED = 32'hff3f_ffff;
    localparam logic [31:0] INST1_AUTO_ONLY = 32'h7f00_0000;
    localparam logic [31:0] INST1_DEFAULT_ENABLE = 32'hff00_0000;

    // controller that sits in each instance's pseudo domain
    localparam int INST0_PSEUDO_INDEX = 15;
    localparam int INST1_PSEUDO_INDEX = 31;

    // controller numbers in instance 0 whose processors have a local reset
    localparam int CPU_HOST_INDEX = 14;
    localparam int CPU_DSP_INDEX = 15;

    localparam logic [1:0] SYNC_RESET_VALUE = 2'h0;

    typedef enum logic [2:0] {
        ST_RESET_HELD_CLOCK_OFF,
        ST_RESET_HELD_CLOCK_ON,
        ST_DISABLE,
        ST_ENABLE,
        ST_AUTO_SLEEP,
        ST_AUTO_WAKE
    } mod_state_e;

    function automatic mod_state_e code_to_state(input logic [CODE_W-1:0] code);
        mod_state_e s;
        s = ST_RESET_HELD_CLOCK_OFF;
        case (code)
            CODE_RESET_HELD_CLOCK_ON: s = ST_RESET_HELD_CLOCK_ON;
            CODE_DISABLE: s = ST_DISABLE;
            CODE_ENABLE: s = ST_ENABLE;
            CODE_AUTO_SLEEP: s = ST_AUTO_SLEEP;
            CODE_AUTO_WAKE: s = ST_AUTO_WAKE;
            default: s = ST_RESET_HELD_CLOCK_OFF;
        endcase
        return s;
    endfunction
endpackage

// >>> local_ctrl_if.sv
// signals between the global part and one local module controller
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface local_ctrl_if;
    logic setNext;
    logic [2:0] nextCode;
    logic go;
    logic access;
    logic emuClkOn;
    logic emuRst;
    logic clkEn;
    logic rstN;
    logic isEnabled;

    modport global_side (
        output setNext,
        output nextCode,
        output go,
        output access,
        output emuClkOn,
        output emuRst,
        input clkEn,
        input rstN,
        input isEnabled
    );
    modport local_side (
        input setNext,
        input nextCode,
        input go,
        input access,
        input emuClkOn,
        input emuRst,
        output clkEn,
        output rstN,
        output isEnabled
    );
endinterface
`default_nettype wire

// >>> local_module_ctrl.sv
// one local module controller: state, pending next state, clock enable and reset
// assumes reset already synchronised by the top module
`timescale 1ns/1ps
`default_nettype none
module local_module_ctrl #(
    parameter bit DEFAULT_ENABLE = 1'b0,
    parameter bit AUTO_ONLY = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    local_ctrl_if.local_side lc
);
    import power_sleep_pkg::*;

    typedef struct packed {
        mod_state_e state;
        mod_state_e next;
        logic clkEn;
        logic rstN;
    } local_s;

    localparam mod_state_e DEFAULT_STATE =
        DEFAULT_ENABLE ? ST_ENABLE : ST_RESET_HELD_CLOCK_OFF;
    localparam local_s RESET_VALUE = '{DEFAULT_STATE, DEFAULT_STATE,
        DEFAULT_ENABLE, DEFAULT_ENABLE};

    local_s st_reg;
    local_s st_next;

    always_comb
    begin
        st_next = st_reg;
        if (lc.setNext)
        begin
            st_next.next = code_to_state(lc.nextCode);
            if (AUTO_ONLY && lc.nextCode != CODE_ENABLE && lc.nextCode != CODE_AUTO_SLEEP
                && lc.nextCode != CODE_AUTO_WAKE)
            begin
                st_next.next = ST_ENABLE;
            end
        end
        if (lc.go)
        begin
            st_next.state = st_next.next;
        end
        else if (st_reg.state == ST_AUTO_WAKE && lc.access)
        begin
            // first access wakes it for good
            st_next.state = ST_ENABLE;
            st_next.next = ST_ENABLE;
        end
        case (st_next.state)
            ST_ENABLE:
            begin
                st_next.clkEn = 1'b1;
                st_next.rstN = 1'b1;
            end
            ST_DISABLE:
            begin
                st_next.clkEn = 1'b0;
                st_next.rstN = 1'b1;
            end
            ST_RESET_HELD_CLOCK_ON:
            begin
                st_next.clkEn = 1'b1;
                st_next.rstN = 1'b0;
            end
            ST_AUTO_SLEEP, ST_AUTO_WAKE:
            begin
                st_next.clkEn = lc.access;
                st_next.rstN = 1'b1;
            end
            default:
            begin
                st_next.clkEn = 1'b0;
                st_next.rstN = 1'b0;
            end
        endcase
        // debug emulation overrides win over the programmed state
        if (lc.emuClkOn)
        begin
            st_next.clkEn = 1'b1;
        end
        if (lc.emuRst)
        begin
            st_next.rstN = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= RESET_VALUE;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign lc.clkEn = st_reg.clkEn;
    assign lc.rstN = st_reg.rstN;
    assign lc.isEnabled = (st_reg.state == ST_ENABLE);
endmodule
`default_nettype wire

// >>> power_sleep_ctrl.sv
// two module-level power, clock and reset gating controllers
// assumes synchronous request inputs; command and go are one-cycle strobes
//
// How it works
// - two instances, each always-on plus pseudo domain
// - local controller holds state machine per module
// - one local controller drives clock and reset
// - all domains on at power-up, never removable
// - power-on sequencing runs with no software
// - ports switch clocks, resets, processor local reset
// - ram sleep for signal processor and shared
// - debug emulation forces clock on or reset
// - instance 0 defaults: reset held or enabled
// - instance 0 ctrl 7 auto only, 8 unused
// - instance 0 ctrls 10-12 enabled, auto only
// - instance 0 ctrl 15 pseudo domain, enabled
// - instance 1 ctrls 0-21 held, 22-23 unused
// - modules without controller keep clock off, reset released
// - enabled runs, disabled stops clock, reset released
// - reset held clock on keeps clock running
// - auto-only modules turn other requests into enable
// - always-on domain refuses to turn off
`timescale 1ns/1ps
`default_nettype none
module power_sleep_ctrl (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cmdValid,
    input wire logic cmdInst,
    input wire logic [power_sleep_pkg::INDEX_W-1:0] cmdIndex,
    input wire logic [power_sleep_pkg::CODE_W-1:0] cmdState,
    input wire logic [1:0] goReq,
    input wire logic [power_sleep_pkg::INST0_COUNT-1:0] access0,
    input wire logic [power_sleep_pkg::INST1_COUNT-1:0] access1,
    input wire logic [power_sleep_pkg::INST0_COUNT-1:0] emuClkOn0,
    input wire logic [power_sleep_pkg::INST0_COUNT-1:0] emuRst0,
    input wire logic [power_sleep_pkg::INST1_COUNT-1:0] emuClkOn1,
    input wire logic [power_sleep_pkg::INST1_COUNT-1:0] emuRst1,
    input wire logic [1:0] cpuLocalRstReq,
    input wire logic [1:0] ramSleepReq,
    input wire logic [1:0] alwaysOnOffReq,
    output logic [power_sleep_pkg::INST0_COUNT-1:0] modClkEn0,
    output logic [power_sleep_pkg::INST0_COUNT-1:0] modRst0_n,
    output logic [power_sleep_pkg::INST1_COUNT-1:0] modClkEn1,
    output logic [power_sleep_pkg::INST1_COUNT-1:0] modRst1_n,
    output logic [1:0] cpuLocalRst_n,
    output logic [1:0] ramSleep,
    output logic [1:0] alwaysOnPower,
    output logic [1:0] pseudoPower,
    output logic [1:0] offRejected
);
    import power_sleep_pkg::*;

    typedef struct packed {
        logic [1:0] sync;
        logic [1:0] cpuRstN;
        logic [1:0] ramSleep;
        logic [1:0] offRejected;
    } top_s;

    top_s st_reg;
    top_s st_next;
    top_s sy_reg;
    logic rst_n;
    logic [INST0_COUNT-1:0] enabled0;
    logic [INST1_COUNT-1:0] enabled1;

    // reset release through two flops; only the second is used
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sy_reg <= '0;
        end
        else
        begin
            sy_reg <= '{ {sy_reg.sync[0], 1'b1}, 2'h0, 2'h0, 2'h0 };
        end
    end
    assign rst_n = sy_reg.sync[1];

    // instance 0 local controllers
    for (genvar i = 0; i < INST0_COUNT; i++)
    begin : g_inst0
        if (INST0_USED[i])
        begin : g_used
            local_ctrl_if lc ();
            assign lc.setNext = cmdValid && !cmdInst
                && cmdIndex == INDEX_W'(i);
            assign lc.nextCode = cmdState;
            assign lc.go = goReq[0];
            assign lc.access = access0[i];
            assign lc.emuClkOn = emuClkOn0[i];
            assign lc.emuRst = emuRst0[i];
            local_module_ctrl #(
                .DEFAULT_ENABLE(INST0_DEFAULT_ENABLE[i]),
                .AUTO_ONLY(INST0_AUTO_ONLY[i])
            ) u_ctrl (
                .clk(clk),
                .rst_n(rst_n),
                .lc(lc.local_side)
            );
            assign modClkEn0[i] = lc.clkEn;
            assign modRst0_n[i] = lc.rstN;
            assign enabled0[i] = lc.isEnabled;
        end
        else
        begin : g_unused
            // unused slot: nothing hangs off it
            assign modClkEn0[i] = 1'b0;
            assign modRst0_n[i] = 1'b1;
            assign enabled0[i] = 1'b0;
        end
    end

    // instance 1 local controllers; ctrl 8 relies on software forcing its moves
    for (genvar i = 0; i < INST1_COUNT; i++)
    begin : g_inst1
        if (INST1_USED[i])
        begin : g_used
            local_ctrl_if lc ();
            assign lc.setNext = cmdValid && cmdInst
                && cmdIndex == INDEX_W'(i);
            assign lc.nextCode = cmdState;
            assign lc.go = goReq[1];
            assign lc.access = access1[i];
            assign lc.emuClkOn = emuClkOn1[i];
            assign lc.emuRst = emuRst1[i];
            local_module_ctrl #(
                .DEFAULT_ENABLE(INST1_DEFAULT_ENABLE[i]),
                .AUTO_ONLY(INST1_AUTO_ONLY[i])
            ) u_ctrl (
                .clk(clk),
                .rst_n(rst_n),
                .lc(lc.local_side)
            );
            assign modClkEn1[i] = lc.clkEn;
            assign modRst1_n[i] = lc.rstN;
            assign enabled1[i] = lc.isEnabled;
        end
        else
        begin : g_unused
            assign modClkEn1[i] = 1'b0;
            assign modRst1_n[i] = 1'b1;
            assign enabled1[i] = 1'b0;
        end
    end

    always_comb
    begin
        st_next = st_reg;
        st_next.sync = SYNC_RESET_VALUE;
        // processor local reset is separate from the module reset
        st_next.cpuRstN = ~cpuLocalRstReq;
        // ram only sleeps while the owning pseudo-domain module is not enabled
        st_next.ramSleep[0] = ramSleepReq[0] && !enabled0[INST0_PSEUDO_INDEX];
        st_next.ramSleep[1] = ramSleepReq[1] && !enabled1[INST1_PSEUDO_INDEX];
        st_next.offRejected = alwaysOnOffReq;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '{2'h0, 2'h3, 2'h0, 2'h0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign cpuLocalRst_n = st_reg.cpuRstN;
    assign ramSleep = st_reg.ramSleep;
    assign offRejected = st_reg.offRejected;
    // power never removed from either domain; no port can lower these
    assign alwaysOnPower = 2'h3;
    assign pseudoPower = 2'h3;
endmodule
`default_nettype wire

// >>> power_sleep_ctrl_checker.sv
// port-level assertions for the gating controller
// assumes binding onto power_sleep_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module power_sleep_ctrl_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cmdValid,
    input wire logic cmdInst,
    input wire logic [4:0] cmdIndex,
    input wire logic [2:0] cmdState,
    input wire logic [1:0] goReq,
    input wire logic [15:0] emuClkOn0,
    input wire logic [15:0] emuRst0,
    input wire logic [1:0] cpuLocalRstReq,
    input wire logic [1:0] ramSleepReq,
    input wire logic [1:0] alwaysOnOffReq,
    input wire logic [15:0] modClkEn0,
    input wire logic [15:0] modRst0_n,
    input wire logic [31:0] modClkEn1,
    input wire logic [31:0] modRst1_n,
    input wire logic [1:0] cpuLocalRst_n,
    input wire logic [1:0] ramSleep,
    input wire logic [1:0] alwaysOnPower,
    input wire logic [1:0] pseudoPower,
    input wire logic [1:0] offRejected
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    domains_on_a: assert property (alwaysOnPower == 2'h3 && pseudoPower == 2'h3)
        else $error("power domain reported off");
    off_refused_a: assert property (alwaysOnOffReq[0] |=> offRejected[0])
        else $error("off request not refused");
    emu_clock_a: assert property (emuClkOn0[0] |=> modClkEn0[0])
        else $error("debug clock force ignored");
    emu_reset_a: assert property (emuRst0[6] |=> !modRst0_n[6])
        else $error("debug reset force ignored");
    unused_slot_a: assert property (!modClkEn0[8] && modRst0_n[8] && modClkEn1[23:22] == 2'h0)
        else $error("unused slot gated");
    auto_reset_a: assert property ((emuRst0 == 16'h0) [*2] |-> &modRst0_n[12:10])
        else $error("auto-only module held in reset");
    cpu_reset_a: assert property (cpuLocalRstReq[0] |=> !cpuLocalRst_n[0])
        else $error("local reset not applied");
    ram_sleep_a: assert property (ramSleep[1] |-> $past(ramSleepReq[1]))
        else $error("ram sleep without request");
    walk_disable_a: assert property ((cmdValid && cmdInst && cmdIndex == 5'h8 &&
        cmdState == 3'h2) ##1 (goReq[1] && !cmdValid) |=> (!modClkEn1[8] && modRst1_n[8]))
        else $error("disable state not applied");
    cover property (goReq[1] ##1 modClkEn1[8]);
    cover property (ramSleep == 2'h3);
    cover property (offRejected == 2'h3);
endmodule
bind power_sleep_ctrl power_sleep_ctrl_checker u_chk (.clk, .arst_n, .cmdValid, .cmdInst,
    .cmdIndex, .cmdState, .goReq, .emuClkOn0, .emuRst0, .cpuLocalRstReq, .ramSleepReq,
    .alwaysOnOffReq, .modClkEn0, .modRst0_n, .modClkEn1, .modRst1_n, .cpuLocalRst_n,
    .ramSleep, .alwaysOnPower, .pseudoPower, .offRejected);
`default_nettype wire

// >>> peripheral_model.sv
// gated peripheral: raises access until served on an enabled clock
// assumes clkEn and rstN come from the controller outputs
`timescale 1ns/1ps
`default_nettype none
module peripheral_model (
    input wire logic clk,
    input wire logic clkEn,
    input wire logic rstN,
    input wire logic want,
    output logic access,
    output logic served
);
    initial access = 1'b0;
    initial served = 1'b0;
    // work only completes while its clock really runs
    always @(posedge clk)
    begin
        served <= access && clkEn && rstN;
        if (want)
            access <= 1'b1;
        else if (access && clkEn && rstN)
            access <= 1'b0;
    end
endmodule
`default_nettype wire

// >>> power_sleep_ctrl_bench.sv
// self-checking bench for the gating controller
// assumes one peripheral model on instance 0 controller 7
`timescale 1ns/1ps
`default_nettype none
module power_sleep_ctrl_bench;
    import power_sleep_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic cmdValid = 1'b0;
    logic cmdInst = 1'b0;
    logic [4:0] cmdIndex = 5'h0;
    logic [2:0] cmdState = 3'h0;
    logic [1:0] goReq = 2'h0;
    logic [15:0] emuClkOn0 = 16'h0;
    logic [15:0] emuRst0 = 16'h0;
    logic [31:0] access1 = 32'h0;
    logic [31:0] emuClkOn1 = 32'h0;
    logic [31:0] emuRst1 = 32'h0;
    logic [1:0] cpuLocalRstReq = 2'h0;
    logic [1:0] ramSleepReq = 2'h0;
    logic [1:0] alwaysOnOffReq = 2'h0;
    logic want = 1'b0;
    logic access7, served;
    logic [15:0] access0, modClkEn0, modRst0_n;
    logic [31:0] modClkEn1, modRst1_n;
    logic [1:0] cpuLocalRst_n, ramSleep, alwaysOnPower, pseudoPower, offRejected;
    int miscompares = 0;
    int nChecks = 0;
    assign access0 = {8'h0, access7, 7'h0};
    always #20 clk = ~clk;
    power_sleep_ctrl u_dut (.clk, .arst_n, .cmdValid, .cmdInst, .cmdIndex, .cmdState, .goReq,
        .access0, .access1, .emuClkOn0, .emuRst0, .emuClkOn1, .emuRst1, .cpuLocalRstReq,
        .ramSleepReq, .alwaysOnOffReq, .modClkEn0, .modRst0_n, .modClkEn1, .modRst1_n,
        .cpuLocalRst_n, .ramSleep, .alwaysOnPower, .pseudoPower, .offRejected);
    peripheral_model u_peer (.clk, .clkEn(modClkEn0[7]), .rstN(modRst0_n[7]), .want,
        .access(access7), .served);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d miscompares=%0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // program then commit in the next cycle; returns with outputs settled
    task automatic cmd(input logic inst, input logic [4:0] idx, input logic [2:0] code);
        @(negedge clk);
        cmdValid = 1'b1;
        cmdInst = inst;
        cmdIndex = idx;
        cmdState = code;
        @(negedge clk);
        cmdValid = 1'b0;
        goReq[inst] = 1'b1;
        @(negedge clk);
        goReq = 2'h0;
    endtask
    task automatic t_defaults();
        check(32'(modClkEn0), 32'h9cc0);
        check(32'(modRst0_n), 32'h9dc0);
        check(modClkEn1, 32'hff00_0000);
        check(modRst1_n, 32'hffc0_0000);
        check(32'({cpuLocalRst_n, ramSleep, offRejected}), 32'h30);
    endtask
    task automatic t_states();
        for (int c = 0; c < 4; c++)
        begin
            cmd(1'b1, 5'h8, 3'(c));
            check(32'({modClkEn1[8], modRst1_n[8]}), 32'({c[0], c[1]}));
        end
        cmd(1'b1, 5'h8, 3'h7);
        check(32'({modClkEn1[8], modRst1_n[8]}), 32'h0);
    endtask
    task automatic t_refuse();
        for (int c = 0; c < 3; c++)
        begin
            cmd(1'b0, 5'ha, 3'(c));
            check(32'({modClkEn0[10], modRst0_n[10]}), 32'h3);
        end
        cmd(1'b0, 5'h8, CODE_ENABLE);
        check(32'({modClkEn0[8], modRst0_n[8]}), 32'h1);
    endtask
    task automatic t_auto(input logic [2:0] code, input logic exp);
        int n;
        cmd(1'b0, 5'h7, code);
        check(32'(modClkEn0[7]), 32'h0);
        want = 1'b1;
        @(negedge clk);
        want = 1'b0;
        n = 0;
        while (served !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 20)
        begin
            miscompares++;
            finish_test();
        end
        @(negedge clk);
        check(32'(modClkEn0[7]), 32'(exp));
    endtask
    task automatic t_emu();
        emuClkOn0[0] = 1'b1;
        emuRst0[6] = 1'b1;
        @(negedge clk);
        check(32'({modClkEn0[0], modRst0_n[6]}), 32'h2);
        emuClkOn0 = 16'h0;
        emuRst0 = 16'h0;
        @(negedge clk);
        check(32'({modClkEn0[0], modRst0_n[6]}), 32'h1);
    endtask
    task automatic t_misc();
        cmd(1'b0, 5'hf, CODE_DISABLE);
        cmd(1'b1, 5'h1f, CODE_DISABLE);
        cpuLocalRstReq = 2'h3;
        ramSleepReq = 2'h3;
        alwaysOnOffReq = 2'h3;
        @(negedge clk);
        check(32'({cpuLocalRst_n, ramSleep}), 32'h3);
        check(32'({offRejected, alwaysOnPower, pseudoPower}), 32'h3f);
        cpuLocalRstReq = 2'h0;
        ramSleepReq = 2'h0;
        alwaysOnOffReq = 2'h0;
        @(negedge clk);
        check(32'({cpuLocalRst_n, ramSleep, offRejected}), 32'h30);
    endtask
    initial
    begin
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_defaults();
        t_states();
        t_refuse();
        t_auto(CODE_AUTO_SLEEP, 1'b0);
        t_auto(CODE_AUTO_WAKE, 1'b1);
        t_emu();
        t_misc();
        finish_test();
    end
endmodule
`default_nettype wire
